// ### rtl/css_defs.vh
// constants for the colour sensor sequencer
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH
`define CSS_REG_ENABLE 5'h00
`define CSS_REG_ITIME 5'h01
`define CSS_REG_WAIT_TIME_VALUE 5'h03
`define CSS_REG_LTL 5'h04
`define CSS_REG_LTH 5'h05
`define CSS_REG_HTL 5'h06
`define CSS_REG_HTH 5'h07
`define CSS_REG_PERSISTENCE_FILTER 5'h0C
`define CSS_REG_CONFIG 5'h0D
`define CSS_REG_CONTROL 5'h0F
`define CSS_REG_ID 5'h12
`define CSS_REG_STATUS 5'h13
`define CSS_REG_DATA0 5'h14
`define CSS_BIT_PON 0
`define CSS_BIT_AEN 1
`define CSS_BIT_WEN 3
`define CSS_BIT_IEN 4
`define CSS_BIT_LONG_WAIT_BIT 1
`define CSS_BIT_AVALID 0
`define CSS_BIT_AINT 4
`define CSS_TYPE_REPEAT 2'h0
`define CSS_TYPE_AUTO 2'h1
`define CSS_TYPE_SPECIAL 2'h3
`define CSS_SF_IRQ_CLR 5'h06
`define CSS_RST_ITIME 8'hFF
`define CSS_RST_WAIT_TIME_VALUE 8'hFF
`define CSS_STEP_US 2400
`define CSS_CLK_MHZ 25
`define CSS_STEP_CYC (`CSS_STEP_US * `CSS_CLK_MHZ)
`define CSS_LONG_MULT 12
`endif

// ### rtl/css_i2c_target.v
// i2c target byte engine: address match, byte in/out, ack
`timescale 1ns/100ps
module css_i2c_target #(
  parameter [6:0] DEV_ADDR = 7'h29
) (
  input wire clk,
  input wire rstn,
  input wire scl,
  input wire sda,
  output reg sda_oe,
  output reg start_p,
  output reg stop_p,
  output reg wr_p,
  output reg [7:0] wr_byte,
  output reg first_p,
  output reg rd_p,
  input wire [7:0] rd_byte
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_WR = 2'd2;
  localparam ST_RD = 2'd3;
  reg [1:0] st_r;
  reg scl_d_r;
  reg sda_d_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg ack_r;
  reg first_r;
  reg nack_r;
  wire rise = scl & ~scl_d_r;
  wire fall = ~scl & scl_d_r;
  wire sta = scl & scl_d_r & sda_d_r & ~sda;
  wire sto = scl & scl_d_r & ~sda_d_r & sda;
  always @(posedge clk) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      first_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe <= 1'b0;
      start_p <= 1'b0;
      stop_p <= 1'b0;
      wr_p <= 1'b0;
      wr_byte <= 8'h00;
      first_p <= 1'b0;
      rd_p <= 1'b0;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
      start_p <= 1'b0;
      stop_p <= 1'b0;
      wr_p <= 1'b0;
      first_p <= 1'b0;
      rd_p <= 1'b0;
      if (sta) begin
        start_p <= 1'b1;
        st_r <= ST_ADDR;
        bit_r <= 4'h0;
        ack_r <= 1'b0;
        sda_oe <= 1'b0;
      end else if (sto) begin
        stop_p <= 1'b1;
        st_r <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (st_r != ST_IDLE) begin
        if (rise && !ack_r) begin
          sh_r <= {sh_r[6:0], sda};
          bit_r <= bit_r + 4'h1;
        end else if (rise && ack_r && st_r == ST_RD) begin
          nack_r <= sda;
        end
        if (fall) begin
          if (ack_r) begin
            ack_r <= 1'b0;
            bit_r <= 4'h0;
            sda_oe <= 1'b0;
            if (st_r == ST_RD) begin
              if (nack_r) begin
                st_r <= ST_IDLE;
              end else begin
                sda_oe <= ~rd_byte[7];
                sh_r <= rd_byte;
                rd_p <= 1'b1;
              end
            end
          end else if (bit_r == 4'h8) begin
            ack_r <= 1'b1;
            if (st_r == ST_ADDR) begin
              if (sh_r[7:1] == DEV_ADDR) begin
                sda_oe <= 1'b1;
                st_r <= sh_r[0] ? ST_RD : ST_WR;
                first_r <= 1'b1;
                nack_r <= 1'b0;
              end else begin
                st_r <= ST_IDLE;
                ack_r <= 1'b0;
              end
            end else if (st_r == ST_WR) begin
              sda_oe <= 1'b1;
              wr_p <= 1'b1;
              wr_byte <= sh_r;
              first_p <= first_r;
              first_r <= 1'b0;
            end else begin
              sda_oe <= 1'b0;
            end
          end else if (st_r == ST_RD && bit_r != 4'h0) begin
            // sh_r shifts once per rise, so the next bit is always at the top
            sda_oe <= ~sh_r[7];
          end
        end
      end
    end
  end
endmodule // css_i2c_target

// ### rtl/css_sequencer.v
// colour sensor sequencer: power states, timing, results, threshold irq
// Functional notes
// - after power-on reset, initialise and enter sleep
// - bus start while asleep moves to idle and checks power-on bit
// - idle with power-on clear returns to sleep
// - idle until measure enable; wait then measure, repeating while enabled
// - four channels integrate together, all results copied at end
// - results double buffered; then advance to next configured state
// - integration and wait time are 2.4 ms times (256 minus value)
// - long-wait bit stretches wait time twelve-fold
// - wait state entered only when wait enable set
// - measurement runs 2.4 ms init then integration state
// - 2.4 ms warm-up on leaving idle with power-on set
// - interrupt flag always evaluated; output gated by enable field
// - two 16-bit thresholds; below low or above high is out of range
// - low tested first; low above high ignores high threshold
// - interrupt only after persistence count of consecutive hits
// - interrupt holds until special-function clear command
// - measurement interrupt asserted at end of integration
// - register port is a 7-bit addressed i2c target
// - read with no new command uses held register address
// - first byte with msb clear is data at stored address
// - command byte is control command or 5-bit register address
// - type 00 repeats address, 01 auto-increments, 11 special
// - special code 00110 clears the interrupt; others reserved
`timescale 1ns/100ps
`include "css_defs.vh"
module css_sequencer #(
  parameter [6:0] DEV_ADDR = 7'h29,
  parameter [7:0] ID_VALUE = 8'h5A, // arbitrary value
  parameter STEP_CYC = `CSS_STEP_CYC
) (
  input wire CLK,
  input wire RSTN,
  input wire SCL,
  input wire SDA_I,
  output reg SDA_O,
  output reg SDA_OE,
  output reg INT_N,
  output reg MEAS_ACTIVE,
  input wire [15:0] ADC_CLEAR,
  input wire [15:0] ADC_RED,
  input wire [15:0] ADC_GREEN,
  input wire [15:0] ADC_BLUE
);
  localparam S_SLEEP = 3'd0;
  localparam S_IDLE = 3'd1;
  localparam S_WARM = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_INIT = 3'd4;
  localparam S_ADC = 3'd5;
  wire scl_s;
  wire sda_s;
  wire oe_w;
  wire start_p;
  wire stop_p;
  wire wr_p;
  wire first_p;
  wire rd_p;
  wire [7:0] wr_byte;
  reg [7:0] rd_byte;
  css_sync u_sscl (.clk(CLK), .rstn(RSTN), .din(SCL), .dout(scl_s));
  css_sync u_ssda (.clk(CLK), .rstn(RSTN), .din(SDA_I), .dout(sda_s));
  css_i2c_target #(.DEV_ADDR(DEV_ADDR)) u_tgt (
    .clk(CLK), .rstn(RSTN), .scl(scl_s), .sda(sda_s), .sda_oe(oe_w),
    .start_p(start_p), .stop_p(stop_p), .wr_p(wr_p), .wr_byte(wr_byte),
    .first_p(first_p), .rd_p(rd_p), .rd_byte(rd_byte));
  reg [7:0] enable_r;
  reg [7:0] itime_r;
  reg [7:0] wait_time_value_r;
  reg [15:0] low_thr_r;
  reg [15:0] high_thr_r;
  reg [7:0] persistence_filter_r;
  reg [7:0] config_r;
  reg [7:0] control_r;
  reg [4:0] addr_r;
  reg [1:0] type_r;
  reg irq_r;
  reg valid_r;
  reg [15:0] ch_r [0:3];
  reg [7:0] hi_shadow_r;
  reg [2:0] st_r;
  reg [24:0] step_cnt_r;
  reg [11:0] steps_r;
  reg [3:0] persistence_filter_cnt_r;
  reg [7:0] ld_r;
  reg [7:0] rdv;
  wire power_on_bit = enable_r[`CSS_BIT_PON];
  wire measure_enable = enable_r[`CSS_BIT_AEN];
  wire wen = enable_r[`CSS_BIT_WEN];
  wire step_p = (step_cnt_r == STEP_CYC - 1);
  wire [8:0] itime_steps = 9'd256 - {1'b0, itime_r};
  wire [8:0] wait_time_value_steps = 9'd256 - {1'b0, wait_time_value_r};
  wire [11:0] wait_steps = config_r[`CSS_BIT_LONG_WAIT_BIT] ?
    {3'b000, wait_time_value_steps} * 12'd12 : {3'b000, wait_time_value_steps};
  // low compare first; a low above high suppresses the high compare
  wire below = ADC_CLEAR < low_thr_r;
  wire above = (low_thr_r <= high_thr_r) && (ADC_CLEAR > high_thr_r);
  wire out_range = below | above;
  reg [3:0] persistence_filter_need;
  always @* begin
    case (persistence_filter_r[3:0])
      4'd0: persistence_filter_need = 4'd0;
      4'd1: persistence_filter_need = 4'd1;
      4'd2: persistence_filter_need = 4'd2;
      4'd3: persistence_filter_need = 4'd3;
      default: persistence_filter_need = 4'd15;
    endcase
  end
  wire cyc_end = (st_r == S_ADC) && step_p && (steps_r == 12'd1);
  wire [4:0] cur_addr = addr_r;
  always @* begin
    case (cur_addr)
      `CSS_REG_ENABLE: rdv = enable_r;
      `CSS_REG_ITIME: rdv = itime_r;
      `CSS_REG_WAIT_TIME_VALUE: rdv = wait_time_value_r;
      `CSS_REG_LTL: rdv = low_thr_r[7:0];
      `CSS_REG_LTH: rdv = low_thr_r[15:8];
      `CSS_REG_HTL: rdv = high_thr_r[7:0];
      `CSS_REG_HTH: rdv = high_thr_r[15:8];
      `CSS_REG_PERSISTENCE_FILTER: rdv = persistence_filter_r;
      `CSS_REG_CONFIG: rdv = config_r;
      `CSS_REG_CONTROL: rdv = control_r;
      `CSS_REG_ID: rdv = ID_VALUE;
      `CSS_REG_STATUS: rdv = {3'b000, irq_r, 3'b000, valid_r};
      5'h14, 5'h16, 5'h18, 5'h1A: rdv = ch_r[cur_addr[2:1] - 2'd2][7:0];
      // high byte comes from the copy taken when the low byte was read
      5'h15, 5'h17, 5'h19, 5'h1B: rdv = hi_shadow_r;
      default: rdv = 8'h00;
    endcase
  end
  always @(posedge CLK) begin
    if (!RSTN) begin
      rd_byte <= 8'h00;
      hi_shadow_r <= 8'h00;
    end else begin
      rd_byte <= rdv;
      if (rd_p && cur_addr >= `CSS_REG_DATA0 && !cur_addr[0]) begin
        hi_shadow_r <= ch_r[cur_addr[2:1] - 2'd2][15:8];
      end
    end
  end
  integer i;
  always @(posedge CLK) begin
    if (!RSTN) begin
      enable_r <= 8'h00;
      itime_r <= `CSS_RST_ITIME;
      wait_time_value_r <= `CSS_RST_WAIT_TIME_VALUE;
      low_thr_r <= 16'h0000;
      high_thr_r <= 16'h0000;
      persistence_filter_r <= 8'h00;
      config_r <= 8'h00;
      control_r <= 8'h00;
      addr_r <= 5'h00;
      type_r <= 2'b00;
      irq_r <= 1'b0;
      valid_r <= 1'b0;
      st_r <= S_SLEEP;
      step_cnt_r <= 25'd0;
      steps_r <= 12'd0;
      persistence_filter_cnt_r <= 4'd0;
      SDA_O <= 1'b0;
      SDA_OE <= 1'b0;
      INT_N <= 1'b1;
      MEAS_ACTIVE <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        ch_r[i] <= 16'h0000;
      end
    end else begin
      SDA_O <= 1'b0;
      SDA_OE <= oe_w;
      INT_N <= ~(irq_r & enable_r[`CSS_BIT_IEN]);
      MEAS_ACTIVE <= (st_r == S_INIT) || (st_r == S_ADC);
      step_cnt_r <= step_p ? 25'd0 : step_cnt_r + 25'd1;
      // bus side: command byte or data byte
      if (wr_p) begin
        if (first_p && wr_byte[7]) begin
          if (wr_byte[6:5] == `CSS_TYPE_SPECIAL) begin
            if (wr_byte[4:0] == `CSS_SF_IRQ_CLR &&
                !(cyc_end && out_range)) begin
              irq_r <= 1'b0;
            end
          end else begin
            addr_r <= wr_byte[4:0];
            type_r <= wr_byte[6:5];
          end
        end else begin
          case (addr_r)
            `CSS_REG_ENABLE: enable_r <= wr_byte;
            `CSS_REG_ITIME: itime_r <= wr_byte;
            `CSS_REG_WAIT_TIME_VALUE: wait_time_value_r <= wr_byte;
            `CSS_REG_LTL: low_thr_r[7:0] <= wr_byte;
            `CSS_REG_LTH: low_thr_r[15:8] <= wr_byte;
            `CSS_REG_HTL: high_thr_r[7:0] <= wr_byte;
            `CSS_REG_HTH: high_thr_r[15:8] <= wr_byte;
            `CSS_REG_PERSISTENCE_FILTER: persistence_filter_r <= wr_byte;
            `CSS_REG_CONFIG: config_r <= wr_byte;
            `CSS_REG_CONTROL: control_r <= wr_byte;
            default: ;
          endcase
          if (type_r == `CSS_TYPE_AUTO) begin
            addr_r <= addr_r + 5'd1;
          end
        end
      end else if (rd_p && type_r == `CSS_TYPE_AUTO) begin
        addr_r <= addr_r + 5'd1;
      end
      // power and measurement sequence
      case (st_r)
        S_SLEEP: begin
          if (start_p) begin
            st_r <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (!power_on_bit) begin
            st_r <= S_SLEEP;
          end else if (measure_enable) begin
            st_r <= S_WARM;
            step_cnt_r <= 25'd0;
            steps_r <= 12'd1;
          end
        end
        S_WARM: begin
          if (step_p) begin
            st_r <= wen ? S_WAIT : S_INIT;
            steps_r <= wen ? wait_steps : 12'd1;
          end
        end
        S_WAIT: begin
          if (step_p) begin
            if (steps_r == 12'd1) begin
              st_r <= S_INIT;
              steps_r <= 12'd1;
            end else begin
              steps_r <= steps_r - 12'd1;
            end
          end
        end
        S_INIT: begin
          if (step_p) begin
            st_r <= S_ADC;
            steps_r <= {3'b000, itime_steps};
          end
        end
        S_ADC: begin
          if (step_p) begin
            if (steps_r == 12'd1) begin
              ch_r[0] <= ADC_CLEAR;
              ch_r[1] <= ADC_RED;
              ch_r[2] <= ADC_GREEN;
              ch_r[3] <= ADC_BLUE;
              valid_r <= 1'b1;
              if (out_range) begin
                if (persistence_filter_cnt_r + 4'd1 >= persistence_filter_need ||
                    persistence_filter_need == 4'd0) begin
                  irq_r <= 1'b1;
                end
                if (persistence_filter_cnt_r != 4'd15) begin
                  persistence_filter_cnt_r <= persistence_filter_cnt_r + 4'd1;
                end
              end else begin
                persistence_filter_cnt_r <= 4'd0;
              end
              if (power_on_bit && measure_enable) begin
                st_r <= wen ? S_WAIT : S_INIT;
                steps_r <= wen ? wait_steps : 12'd1;
              end else begin
                st_r <= S_IDLE;
              end
            end else begin
              steps_r <= steps_r - 12'd1;
            end
          end
        end
        default: st_r <= S_SLEEP;
      endcase
      if (st_r != S_SLEEP && st_r != S_IDLE && !(power_on_bit && measure_enable)) begin
        st_r <= S_IDLE;
      end
    end
  end
endmodule // css_sequencer

// ### rtl/css_sync.v
// three-stage synchroniser with agreement filter for bus pins
`timescale 1ns/100ps
module css_sync (
  input wire clk,
  input wire rstn,
  input wire din,
  output reg dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg hold_r;
  // output follows the agreeing stages directly; saves a cycle of link
  // latency so the data pin is released well before the next clock rise
  always @* begin
    dout = (s2_r == s3_r) ? s3_r : hold_r;
  end
  always @(posedge clk) begin
    if (!rstn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      hold_r <= 1'b1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      hold_r <= dout;
    end
  end
endmodule // css_sync

// ### verif/css_i2c_host.sv
// i2c controller model driving the sensor's bus pins
`timescale 1ns/100ps
module css_i2c_host (
  input wire clk,
  input wire dev_oe,
  output reg scl,
  output wire sda
);
  reg h_oe = 1'b0;
  initial scl = 1'b1;
  // pull-up: a released line reads high, never the last value
  assign sda = ~(h_oe | dev_oe);
  task tk(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // link clock stands high between frames, eight cycles per bit
  task start;
    begin
      h_oe = 1'b0;
      tk(2);
      scl = 1'b1;
      tk(2);
      h_oe = 1'b1;
      tk(2);
      scl = 1'b0;
    end
  endtask
  task stop;
    begin
      tk(2);
      h_oe = 1'b1;
      tk(2);
      scl = 1'b1;
      tk(2);
      h_oe = 1'b0;
      tk(4);
    end
  endtask
  // eight data bits msb first plus the ninth acknowledge bit
  // long low phase: the target releases or drives data late after a fall
  task xfer(input [8:0] d, output [8:0] q);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        tk(5);
        h_oe = ~d[i];
        tk(1);
        scl = 1'b1;
        tk(2);
        q[i] = sda;
        scl = 1'b0;
      end
    end
  endtask
endmodule // css_i2c_host

// ### verif/css_seq_props.sv
// port-level assertions for the colour sensor sequencer
`timescale 1ns/100ps
module css_seq_props #(
  parameter STEP_CYC = 60000
) (
  input wire CLK,
  input wire RSTN,
  input wire SCL,
  input wire SDA_O,
  input wire SDA_OE,
  input wire INT_N,
  input wire MEAS_ACTIVE
);
  reg scl_d_r;
  reg [7:0] bus_idle_r;
  reg [7:0] since_meas_r;
  reg [31:0] meas_cnt_r;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // bus_idle_r counts cycles since the last link clock edge, saturating
  always @(posedge CLK) begin
    if (!RSTN) begin
      scl_d_r <= 1'b1;
      bus_idle_r <= 8'hff;
      since_meas_r <= 8'hff;
      meas_cnt_r <= 32'h0000_0000;
    end else begin
      scl_d_r <= SCL;
      if (SCL != scl_d_r)
        bus_idle_r <= 8'h00;
      else if (bus_idle_r != 8'hff)
        bus_idle_r <= bus_idle_r + 8'h01;
      if (MEAS_ACTIVE)
        since_meas_r <= 8'h00;
      else if (since_meas_r != 8'hff)
        since_meas_r <= since_meas_r + 8'h01;
      meas_cnt_r <= MEAS_ACTIVE ? meas_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0)
    !RSTN |=> INT_N && !MEAS_ACTIVE && !SDA_OE)
    else $error("outputs not quiet after reset");
  a_open_drain: assert property (SDA_O == 1'b0)
    else $error("data pin driven high");
  a_ack_stands: assert property ($rose(SDA_OE) |-> SDA_OE [*3])
    else $error("data pull too short");
  a_oe_in_frame: assert property (SDA_OE |-> bus_idle_r < 8'd40)
    else $error("data pulled while bus idle");
  a_meas_len_max: assert property (
    MEAS_ACTIVE |-> meas_cnt_r < 257 * STEP_CYC)
    else $error("measurement too long");
  a_meas_min: assert property ($rose(MEAS_ACTIVE) |-> MEAS_ACTIVE [*8])
    else $error("measurement too short");
  a_irq_release: assert property ($rose(INT_N) |-> bus_idle_r < 8'd40)
    else $error("interrupt released without a command");
  a_irq_source: assert property ($fell(INT_N) |->
    since_meas_r < 8'd8 || bus_idle_r < 8'd40)
    else $error("interrupt raised outside cycle end");
endmodule // css_seq_props
bind css_sequencer css_seq_props #(.STEP_CYC(STEP_CYC)) css_seq_props_inst (
  .CLK(CLK),
  .RSTN(RSTN),
  .SCL(SCL),
  .SDA_O(SDA_O),
  .SDA_OE(SDA_OE),
  .INT_N(INT_N),
  .MEAS_ACTIVE(MEAS_ACTIVE)
);

// ### verif/css_sequencer_tb.sv
// self-checking bench for the colour sensor sequencer
`timescale 1ns/100ps
module css_sequencer_tb;
  localparam STEP = 50;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg [15:0] adc_c = 16'h0000;
  reg [15:0] adc_r = 16'h0000;
  wire scl;
  wire sda_i;
  wire sda_oe;
  wire int_n;
  wire meas;
  integer miscompares = 0;
  integer cmp_count = 0;
  integer k;
  integer n;
  reg [31:0] seed = 32'h0000_fba3;
  reg [8:0] q;
  reg [15:0] thr;
  reg [15:0] got;
  always #20 clk = ~clk;
  css_sequencer #(.STEP_CYC(STEP)) css_sequencer_inst (
    .CLK(clk),
    .RSTN(rstn),
    .SCL(scl),
    .SDA_I(sda_i),
    .SDA_O(),
    .SDA_OE(sda_oe),
    .INT_N(int_n),
    .MEAS_ACTIVE(meas),
    .ADC_CLEAR(adc_c),
    .ADC_RED(adc_r),
    .ADC_GREEN(~adc_r),
    .ADC_BLUE(adc_r ^ adc_c)
  );
  css_i2c_host css_i2c_host_inst (
    .clk(clk),
    .dev_oe(sda_oe),
    .scl(scl),
    .sda(sda_i)
  );
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task stop_test;
    begin
      if (miscompares == 0 && cmp_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [15:0] e, input [15:0] g, input [95:0] nm);
    begin
      cmp_count = cmp_count + 1;
      if (e !== g) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task sendb(input [7:0] b);
    begin
      css_i2c_host_inst.xfer({b, 1'b1}, q);
      chk(16'h0000, {15'h0000, q[0]}, "ack");
    end
  endtask
  // command byte first, then up to two data bytes low first
  task wr(input [7:0] c, input [15:0] d, input integer nb);
    begin
      css_i2c_host_inst.start;
      sendb(8'h52);
      sendb(c);
      if (nb > 0)
        sendb(d[7:0]);
      if (nb > 1)
        sendb(d[15:8]);
      css_i2c_host_inst.stop;
    end
  endtask
  task rd2(output [15:0] d);
    begin
      css_i2c_host_inst.start;
      sendb(8'h53);
      css_i2c_host_inst.xfer(9'h1fe, q);
      d[7:0] = q[8:1];
      css_i2c_host_inst.xfer(9'h1ff, q);
      d[15:8] = q[8:1];
      css_i2c_host_inst.stop;
    end
  endtask
  task wm(input v);
    begin
      n = 0;
      while (meas !== v && n < 20000) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n >= 20000) begin
        miscompares = miscompares + 1;
        stop_test;
      end
    end
  endtask
  task cyc_int(input e);
    begin
      wm(1'b1);
      wm(1'b0);
      repeat (3) @(negedge clk);
      chk({15'h0000, e}, {15'h0000, int_n}, "int_n");
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk(16'h0001, {15'h0000, int_n}, "int_n rst");
    chk(16'h0000, {15'h0000, meas}, "meas rst");
    css_i2c_host_inst.start;
    css_i2c_host_inst.xfer({8'h54, 1'b1}, q);
    chk(16'h0001, {15'h0000, q[0]}, "nack");
    css_i2c_host_inst.stop;
    wr(8'h93, 16'h00ff, 1);
    rd2(got);
    chk(16'h0000, got, "status rst");
    wr(8'ha1, 16'h00fe, 1);
    wr(8'ha6, 16'h0000, 2);
    wr(8'ha0, 16'h001b, 1);
    wr(8'h80, 16'h0000, 0);
    rd2(got);
    chk(16'h1b1b, got, "enable");
    for (k = 0; k < 3; k = k + 1) begin
      seed = lfsr(seed);
      thr = seed[15:0] | 16'h0100;
      adc_c = 16'hffff;
      adc_r = seed[31:16];
      wr(8'ha4, thr, 2);
      wr(8'hac, k[15:0], 1);
      // half-written thresholds may have flagged a hit; start clean
      wr(8'he6, 16'h0000, 0);
      cyc_int(1'b1);
      adc_c = thr - 16'h0001;
      wm(1'b1);
      wm(1'b0);
      chk(16'h0001, {15'h0000, n >= 3 * STEP - 1 && n <= 3 * STEP + 1},
        "meas len");
      repeat (3) @(negedge clk);
      chk({15'h0000, k == 2}, {15'h0000, int_n}, "int persistence_filter");
      cyc_int(1'b0);
      wr(8'h93, 16'h0000, 0);
      rd2(got);
      chk(16'h1111, got, "status");
      wr(8'hb4, 16'h0000, 0);
      rd2(got);
      chk(thr - 16'h0001, got, "clear data");
      adc_c = thr;
      wr(8'he5, 16'h0000, 0);
      chk(16'h0000, {15'h0000, int_n}, "reserved sf");
      wr(8'he6, 16'h0000, 0);
      repeat (4) @(negedge clk);
      chk(16'h0001, {15'h0000, int_n}, "int clr");
      cyc_int(1'b1);
    end
    wr(8'had, 16'h0002, 1);
    wm(1'b1);
    wm(1'b0);
    wm(1'b1);
    chk(16'h0001, {15'h0000, n >= 12 * STEP - 1 && n <= 12 * STEP + 1},
      "long wait");
    // a long integration keeps the abort well clear of a cycle end
    wr(8'ha1, 16'h0000, 1);
    wm(1'b0);
    wm(1'b1);
    wr(8'ha0, 16'h0000, 1);
    repeat (300) @(negedge clk);
    chk(16'h0000, {15'h0000, meas}, "meas off");
    stop_test;
  end
endmodule // css_sequencer_tb
